/* inc/exec_pkg.sv */
// constants, opcode patterns and types for the byte-op / skip / branch execution block
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int PC_W = 11;
   localparam int FADDR_W = 5;
   localparam int INSTR_W = 12;
   // field positions inside the instruction word and the status register
   localparam int DEST_BIT = 5;
   localparam int JUMP_MSB = 8;
   localparam int LIT_MSB = 7;
   localparam int STATUS_PAGE_HI = 6;
   localparam int STATUS_PAGE_LO = 5;
   // reset values
   localparam logic [10:0] PC_RESET = 11'h000;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic ZERO_RESET = 1'b0;
   // opcode patterns and the masks that select their fixed bits
   localparam logic [11:0] MASK_FD = 12'hFC0;
   localparam logic [11:0] MASK_F = 12'hFE0;
   localparam logic [11:0] MASK_JUMP = 12'hE00;
   localparam logic [11:0] MASK_LIT = 12'hF00;
   localparam logic [11:0] OP_DEC_SKIP = 12'h2C0;
   localparam logic [11:0] OP_ADD_ONE = 12'h280;
   localparam logic [11:0] OP_ADD_SKIP = 12'h3C0;
   localparam logic [11:0] OP_JUMP = 12'hA00;
   localparam logic [11:0] OP_OR_IMM = 12'hD00;
   localparam logic [11:0] OP_OR_FILE = 12'h100;
   localparam logic [11:0] OP_STORE_ACC = 12'h020;
   localparam logic [11:0] OP_COPY_FILE = 12'h200;

   typedef enum logic [2:0] {
      ALU_PASS_F = 3'h0,
      ALU_DEC = 3'h1,
      ALU_INC = 3'h2,
      ALU_OR_F = 3'h3,
      ALU_OR_K = 3'h4,
      ALU_PASS_W = 3'h5
   } alu_op_type;

   typedef enum logic [1:0] {
      ST_EXEC = 2'b01,
      ST_FLUSH = 2'b10
   } state_type;
endpackage : exec_pkg

/* inc/alu_if.sv */
// operand and result bundle between the executer and its arithmetic unit
`timescale 1ns/100ps
interface alu_if;
   exec_pkg::alu_op_type op;
   logic [7:0] acc;
   logic [7:0] file_val;
   logic [7:0] literal;
   logic [7:0] result;
   logic zero;
   modport ctrl_side (output op, output acc, output file_val, output literal, input result, input zero);
   modport alu_side (input op, input acc, input file_val, input literal, output result, output zero);
endinterface : alu_if

/* logic/alu_unit.sv */
// eight-bit arithmetic and logic unit for the byte operations
`timescale 1ns/100ps
module alu_unit
(
   alu_if.alu_side bus // operands in, result and zero out
);
   // result selection per operation
   always_comb
   begin
      case (bus.op)
         exec_pkg::ALU_DEC: bus.result = bus.file_val - 8'h01;
         exec_pkg::ALU_INC: bus.result = bus.file_val + 8'h01;
         exec_pkg::ALU_OR_F: bus.result = bus.acc | bus.file_val;
         exec_pkg::ALU_OR_K: bus.result = bus.acc | bus.literal;
         exec_pkg::ALU_PASS_W: bus.result = bus.acc;
         default: bus.result = bus.file_val;
      endcase
   end

   // zero detect on the full eight bits
   assign bus.zero = (bus.result == 8'h00);
endmodule : alu_unit

/* logic/byte_op_skip_branch_exec.sv */
// execution of decrement/increment with skip, absolute jump, OR and moves
`timescale 1ns/100ps
module byte_op_skip_branch_exec
(
   input wire logic MCLK, // core clock, 40 MHz
   input wire logic RESET, // synchronous reset, active high
   input wire logic [11:0] INSTR, // instruction word executing this cycle
   input wire logic [7:0] STATUS_IN, // status register contents
   input wire logic [7:0] FILE_RDATA, // data of the addressed file register
   output logic [10:0] PC, // program counter, fetch address
   output logic [7:0] ACC, // accumulator
   output logic ZERO, // zero flag
   output logic [4:0] FILE_ADDR, // file register address
   output logic [7:0] FILE_WDATA, // file write data
   output logic FILE_WE, // file write strobe, one cycle
   output logic DISCARD // prefetched instruction being discarded
);
   alu_if alu_bus ();
   exec_pkg::state_type state;
   exec_pkg::state_type next_state;
   logic exec;
   logic is_dec_skip, is_add_one, is_add_skip, is_jump;
   logic is_or_imm, is_or_file, is_store, is_copy;
   logic dest_file;
   logic write_file, write_acc, update_zero, skip_req;
   logic [10:0] jump_target;

   alu_unit alu (
      .bus(alu_bus)
   );

   // a discarded slot executes as a no-op
   assign exec = (state == exec_pkg::ST_EXEC);
   assign dest_file = INSTR[exec_pkg::DEST_BIT];

   // opcode decode; unlisted opcodes belong to other logic and do nothing here
   assign is_dec_skip = exec && ((INSTR & exec_pkg::MASK_FD) == exec_pkg::OP_DEC_SKIP);
   assign is_add_one = exec && ((INSTR & exec_pkg::MASK_FD) == exec_pkg::OP_ADD_ONE);
   assign is_add_skip = exec && ((INSTR & exec_pkg::MASK_FD) == exec_pkg::OP_ADD_SKIP);
   assign is_jump = exec && ((INSTR & exec_pkg::MASK_JUMP) == exec_pkg::OP_JUMP);
   assign is_or_imm = exec && ((INSTR & exec_pkg::MASK_LIT) == exec_pkg::OP_OR_IMM);
   assign is_or_file = exec && ((INSTR & exec_pkg::MASK_FD) == exec_pkg::OP_OR_FILE);
   assign is_store = exec && ((INSTR & exec_pkg::MASK_F) == exec_pkg::OP_STORE_ACC);
   assign is_copy = exec && ((INSTR & exec_pkg::MASK_FD) == exec_pkg::OP_COPY_FILE);

   // operation select for the arithmetic unit
   always_comb
   begin
      if (is_dec_skip)
         alu_bus.op = exec_pkg::ALU_DEC;
      else if (is_add_one || is_add_skip)
         alu_bus.op = exec_pkg::ALU_INC;
      else if (is_or_file)
         alu_bus.op = exec_pkg::ALU_OR_F;
      else if (is_or_imm)
         alu_bus.op = exec_pkg::ALU_OR_K;
      else if (is_store)
         alu_bus.op = exec_pkg::ALU_PASS_W;
      else
         alu_bus.op = exec_pkg::ALU_PASS_F;
   end

   assign alu_bus.acc = ACC;
   assign alu_bus.file_val = FILE_RDATA;
   assign alu_bus.literal = INSTR[exec_pkg::LIT_MSB:0];

   // destinations and flag effects
   assign write_file = ((is_dec_skip || is_add_one || is_add_skip || is_or_file || is_copy) && dest_file)
      || is_store;
   assign write_acc = ((is_dec_skip || is_add_one || is_add_skip || is_or_file || is_copy) && !dest_file)
      || is_or_imm;
   assign update_zero = is_add_one || is_or_imm || is_or_file || is_copy;
   assign skip_req = (is_dec_skip || is_add_skip) && alu_bus.zero;

   // upper counter bits come from the page bits of status, not from the operand
   assign jump_target = {STATUS_IN[exec_pkg::STATUS_PAGE_HI:exec_pkg::STATUS_PAGE_LO],
      INSTR[exec_pkg::JUMP_MSB:0]};

   // file port: address straight from the operand field, any of 0..31
   assign FILE_ADDR = INSTR[4:0];
   assign FILE_WDATA = alu_bus.result;
   assign FILE_WE = write_file;
   assign DISCARD = (state == exec_pkg::ST_FLUSH);

   // one flush cycle after a taken skip or a jump
   always_comb
   begin
      case (state)
         exec_pkg::ST_EXEC:
            next_state = (skip_req || is_jump) ? exec_pkg::ST_FLUSH : exec_pkg::ST_EXEC;
         exec_pkg::ST_FLUSH:
            next_state = exec_pkg::ST_EXEC;
         default:
            next_state = exec_pkg::ST_EXEC;
      endcase
   end

   // state register
   always_ff @(posedge MCLK)
   begin
      if (RESET)
         state <= exec_pkg::ST_EXEC;
      else
         state <= next_state;
   end

   // program counter: jump loads target, otherwise step on every cycle
   always_ff @(posedge MCLK)
   begin
      if (RESET)
         PC <= exec_pkg::PC_RESET;
      else if (is_jump)
         PC <= jump_target;
      else
         PC <= PC + 11'h001;
   end

   // accumulator
   always_ff @(posedge MCLK)
   begin
      if (RESET)
         ACC <= exec_pkg::ACC_RESET;
      else if (write_acc)
         ACC <= alu_bus.result;
   end

   // zero flag; skip ops, jump and store leave it alone
   always_ff @(posedge MCLK)
   begin
      if (RESET)
         ZERO <= exec_pkg::ZERO_RESET;
      else if (update_zero)
         ZERO <= alu_bus.zero;
   end

   // checks
   a_dec_skip_flush: assert property (@(posedge MCLK) disable iff (RESET)
      is_dec_skip && alu_bus.zero |=> DISCARD ##1 !DISCARD)
      else $error("zero decrement did not discard one slot");
   a_dec_no_skip: assert property (@(posedge MCLK) disable iff (RESET)
      is_dec_skip && !alu_bus.zero |=> !DISCARD)
      else $error("nonzero decrement discarded a slot");
   a_dec_flags_kept: assert property (@(posedge MCLK) disable iff (RESET)
      is_dec_skip |=> $stable(ZERO))
      else $error("decrement-and-skip changed zero flag");
   a_dest_acc_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_dec_skip && !dest_file |-> !FILE_WE ##1 ACC == $past(FILE_RDATA) - 8'h01)
      else $error("decrement result not in accumulator");
   a_dest_file_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_add_skip && dest_file |-> FILE_WE && FILE_WDATA == FILE_RDATA + 8'h01 ##1 $stable(ACC))
      else $error("increment result not written back to file");
   a_inc_zero_flag: assert property (@(posedge MCLK) disable iff (RESET)
      is_add_one |=> ZERO == ($past(FILE_RDATA) == 8'hFF))
      else $error("increment zero flag wrong");
   a_add_skip_flush: assert property (@(posedge MCLK) disable iff (RESET)
      is_add_skip |=> DISCARD == ($past(FILE_RDATA) == 8'hFF))
      else $error("increment skip wrong");
   a_jump_target: assert property (@(posedge MCLK) disable iff (RESET)
      is_jump |=> PC == {$past(STATUS_IN[6:5]), $past(INSTR[8:0])} && $stable(ZERO))
      else $error("jump target or flags wrong");
   a_jump_two_cycle: assert property (@(posedge MCLK) disable iff (RESET)
      is_jump |=> DISCARD ##1 !DISCARD && PC == $past(PC) + 11'h001)
      else $error("jump not two cycles");
   a_or_imm_acc: assert property (@(posedge MCLK) disable iff (RESET)
      is_or_imm |=> ACC == ($past(ACC) | $past(INSTR[7:0])) && ZERO == (ACC == 8'h00))
      else $error("or-immediate result wrong");
   a_or_file_zero: assert property (@(posedge MCLK) disable iff (RESET)
      is_or_file |=> ZERO == (($past(ACC) | $past(FILE_RDATA)) == 8'h00))
      else $error("or-with-file zero flag wrong");
   a_store_acc_file: assert property (@(posedge MCLK) disable iff (RESET)
      is_store |-> FILE_WE && FILE_WDATA == ACC && FILE_ADDR == INSTR[4:0] ##1 $stable(ZERO))
      else $error("store-accumulator wrong");
   a_copy_zero_test: assert property (@(posedge MCLK) disable iff (RESET)
      is_copy && dest_file |-> FILE_WDATA == FILE_RDATA ##1 ZERO == ($past(FILE_RDATA) == 8'h00))
      else $error("copy-file zero test wrong");

   // discarded slot: no write, no flag or accumulator change, counter still steps
   a_flush_no_write: assert property (@(posedge MCLK) disable iff (RESET)
      DISCARD |-> !FILE_WE)
      else $error("discarded slot wrote the file space");
   a_flush_regs_kept: assert property (@(posedge MCLK) disable iff (RESET)
      DISCARD |=> $stable(ACC) && $stable(ZERO))
      else $error("discarded slot changed accumulator or zero flag");
   a_flush_one_slot: assert property (@(posedge MCLK) disable iff (RESET)
      DISCARD |=> !DISCARD)
      else $error("discard lasted more than one slot");
   a_flush_pc_step: assert property (@(posedge MCLK) disable iff (RESET)
      DISCARD |=> PC == $past(PC) + 11'h001)
      else $error("counter did not step over the discarded slot");

   // a jump only touches the counter
   a_jump_low_bits: assert property (@(posedge MCLK) disable iff (RESET)
      is_jump |=> PC[8:0] == $past(INSTR[8:0]))
      else $error("jump low counter bits wrong");
   a_jump_no_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_jump |-> !FILE_WE ##1 $stable(ACC))
      else $error("jump wrote data");

   // destination routing per operation
   a_inc_acc_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_add_one && !dest_file |-> !FILE_WE ##1 ACC == $past(FILE_RDATA) + 8'h01)
      else $error("increment result not in accumulator");
   a_inc_file_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_add_one && dest_file |-> FILE_WE && FILE_WDATA == FILE_RDATA + 8'h01 ##1 $stable(ACC))
      else $error("increment result not written back to file");
   a_dec_file_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_dec_skip && dest_file |-> FILE_WE && FILE_WDATA == FILE_RDATA - 8'h01 ##1 $stable(ACC))
      else $error("decrement result not written back to file");
   a_or_file_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_or_file && dest_file |-> FILE_WE && FILE_WDATA == (ACC | FILE_RDATA) ##1 $stable(ACC))
      else $error("or-with-file result not written back to file");
   a_or_file_acc: assert property (@(posedge MCLK) disable iff (RESET)
      is_or_file && !dest_file |-> !FILE_WE ##1 ACC == ($past(ACC) | $past(FILE_RDATA)))
      else $error("or-with-file result not in accumulator");
   a_or_imm_no_write: assert property (@(posedge MCLK) disable iff (RESET)
      is_or_imm |-> !FILE_WE)
      else $error("or-immediate wrote the file space");
   a_store_acc_kept: assert property (@(posedge MCLK) disable iff (RESET)
      is_store |=> $stable(ACC))
      else $error("store-accumulator changed the accumulator");
   a_copy_acc_load: assert property (@(posedge MCLK) disable iff (RESET)
      is_copy && !dest_file |-> !FILE_WE ##1 ACC == $past(FILE_RDATA) && ZERO == ($past(FILE_RDATA) == 8'h00))
      else $error("copy-file to accumulator wrong");
endmodule : byte_op_skip_branch_exec

/* tb/file_space.sv */
// file register space model on the far side of the execution block
`timescale 1ns/100ps
module file_space
(
   input wire logic clk, // core clock
   input wire logic [4:0] addr, // register address
   input wire logic [7:0] wdata, // write data
   input wire logic we, // write strobe
   output logic [7:0] rdata // read data, same cycle
);
   logic [7:0] mem [32];
   // all 32 places readable at once, no wait states
   assign rdata = mem[addr];
   // write lands at the edge that ends the instruction
   always @(posedge clk)
      if (we) mem[addr] <= wdata;
   initial foreach (mem[i]) mem[i] = 8'h00;
endmodule : file_space

/* tb/byte_op_skip_branch_exec_tb.sv */
// self-checking bench for the byte-op / skip / branch execution block
`timescale 1ns/100ps
module byte_op_skip_branch_exec_tb;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   logic [11:0] instr = 12'h000;
   logic [7:0] status = 8'h00;
   logic [7:0] rdata;
   logic [10:0] pc;
   logic [7:0] acc;
   logic zero;
   logic [4:0] faddr;
   logic [7:0] wdata;
   logic we;
   logic discard;
   int err_count = 0;
   int total_checks = 0;
   int cycles = 0;
   // 40 MHz core clock
   always #12.5 mclk = ~mclk;
   byte_op_skip_branch_exec byte_op_skip_branch_exec_inst
   (
      .MCLK(mclk), .RESET(reset), .INSTR(instr), .STATUS_IN(status), .FILE_RDATA(rdata), .PC(pc), .ACC(acc),
      .ZERO(zero), .FILE_ADDR(faddr), .FILE_WDATA(wdata), .FILE_WE(we), .DISCARD(discard)
   );
   file_space file_space_inst (.clk(mclk), .addr(faddr), .wdata(wdata), .we(we), .rdata(rdata));
   task end_sim;
      $display("mismatches %0d of %0d checks", err_count, total_checks);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : end_sim
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // word goes in at a rising edge; 1 ns later that edge's updates have landed
   task run(input logic [11:0] op, input logic [11:0] arg);
      @(posedge mclk);
      instr <= op | arg;
      #1;
   endtask : run
   task pre(input int a, input logic [7:0] v);
      file_space_inst.mem[a] = v;
   endtask : pre
   // wrap to zero sets the flag, the next non-zero result clears it
   task t_add_one;
      pre(5, 8'hFF);
      pre(6, 8'h07);
      run(exec_pkg::OP_ADD_ONE, 12'h005);
      chk(we, 1'b0);
      run(exec_pkg::OP_ADD_ONE, 12'h026);
      chk({we, wdata}, {1'b1, 8'h08});
      chk({acc, zero}, {8'h00, 1'b1});
      run(12'h000, 12'h000);
      chk({acc, zero, file_space_inst.mem[6]}, {8'h00, 1'b0, 8'h08});
   endtask : t_add_one
   // zero flag is 0 here, so a wrongly set flag on a zero result shows
   task t_dec;
      pre(3, 8'h02);
      run(exec_pkg::OP_DEC_SKIP, 12'h003);
      chk(we, 1'b0);
      run(exec_pkg::OP_DEC_SKIP, 12'h023);
      chk({acc, zero, discard}, {8'h01, 2'b00});
      chk({we, wdata}, {1'b1, 8'h01});
      run(exec_pkg::OP_DEC_SKIP, 12'h023);
      chk({file_space_inst.mem[3], wdata}, {8'h01, 8'h00});
      run(exec_pkg::OP_STORE_ACC, 12'h009);
      chk({discard, we, zero}, 3'b100);
      run(12'h000, 12'h000);
      chk({discard, acc, file_space_inst.mem[9]}, {1'b0, 8'h01, 8'h00});
   endtask : t_dec
   task t_add_skip;
      pre(7, 8'hFF);
      pre(8, 8'h03);
      run(exec_pkg::OP_ADD_SKIP, 12'h027);
      chk({we, wdata}, {1'b1, 8'h00});
      run(12'h000, 12'h000);
      chk({discard, file_space_inst.mem[7]}, {1'b1, 8'h00});
      run(exec_pkg::OP_ADD_SKIP, 12'h008);
      run(12'h000, 12'h000);
      chk({acc, discard}, {8'h04, 1'b0});
   endtask : t_add_skip
   // page bits come from status, the operand fills the low nine bits
   task t_jump;
      logic [8:0] k [2] = '{9'h123, 9'h1FF};
      logic [7:0] s [2] = '{8'h40, 8'h20};
      logic [10:0] e [2] = '{11'h523, 11'h3FF};
      for (int i = 0; i < 2; i++)
      begin
         @(posedge mclk);
         status <= s[i];
         instr <= exec_pkg::OP_JUMP | {3'h0, k[i]};
         #1;
         run(12'h000, 12'h000);
         chk({pc, discard, zero}, {e[i], 2'b10});
         run(12'h000, 12'h000);
         chk({pc, discard}, {e[i] + 11'h001, 1'b0});
      end
   endtask : t_jump
   task t_or_move;
      pre(0, 8'h00);
      pre(10, 8'h5A);
      run(exec_pkg::OP_COPY_FILE, 12'h000);
      chk(we, 1'b0);
      run(exec_pkg::OP_OR_IMM, 12'h0A5);
      chk({acc, zero}, {8'h00, 1'b1});
      run(exec_pkg::OP_OR_FILE, 12'h02A);
      chk({acc, zero}, {8'hA5, 1'b0});
      chk({we, wdata}, {1'b1, 8'hFF});
      run(exec_pkg::OP_STORE_ACC, 12'h01F);
      chk({acc, file_space_inst.mem[10]}, {8'hA5, 8'hFF});
      chk({we, wdata}, {1'b1, 8'hA5});
      chk(faddr, 5'h1F);
      run(exec_pkg::OP_COPY_FILE, 12'h020);
      chk({file_space_inst.mem[31], zero, we}, {8'hA5, 2'b01});
      run(12'h000, 12'h000);
      chk({acc, zero}, {8'hA5, 1'b1});
   endtask : t_or_move
   // reset in mid-run while a jump's flush slot is pending; held two edges so
   // the checks never start on state that reset has not yet cleared
   task t_reset;
      run(exec_pkg::OP_JUMP, 12'h0FF);
      @(posedge mclk);
      reset <= 1'b1;
      instr <= 12'h000;
      #1;
      chk({pc, discard}, {11'h2FF, 1'b1});
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      #1;
      chk({pc, acc, zero, discard}, {11'h000, 8'h00, 2'b00});
      run(exec_pkg::OP_OR_IMM, 12'h000);
      run(12'h000, 12'h000);
      chk({acc, zero}, {8'h00, 1'b1});
   endtask : t_reset
   initial
   begin
      // reset high for the first five edges
      repeat (4) @(posedge mclk);
      #1;
      chk({pc, acc, zero, discard}, 16'h0000);
      @(posedge mclk);
      reset <= 1'b0;
      t_add_one();
      t_dec();
      t_add_skip();
      t_jump();
      t_or_move();
      t_reset();
      end_sim();
   end
   // hang guard, far above the few dozen cycles the run needs
   always @(posedge mclk)
   begin
      cycles <= cycles + 1;
      if (cycles == 1000)
      begin
         err_count++;
         end_sim();
      end
   end
endmodule : byte_op_skip_branch_exec_tb
